// ==== core/tick_pkg.sv ====
// Package for the periodic tick counter: register map, field layout, reset values, divider table
package tick_pkg;

  // ****************************************************
  // Register map
  // ****************************************************
  localparam int          ADDR_W        = 2;
  localparam logic [1:0]  OFF_STATUS    = 2'h0;
  localparam logic [1:0]  OFF_COUNT     = 2'h1;
  localparam logic [1:0]  OFF_LIMIT     = 2'h2;

  // ****************************************************
  // Field positions and reset values
  // ****************************************************
  localparam int          FLAG_BIT      = 7;
  localparam int          SRC_HI        = 6;
  localparam int          SRC_LO        = 5;
  localparam int          IE_BIT        = 4;
  localparam int          PS_HI         = 3;
  localparam int          PS_LO         = 0;
  localparam logic [7:0]  CTRL_RESET    = 8'h00;
  localparam logic [7:0]  COUNT_RESET   = 8'h00;
  localparam logic [7:0]  LIMIT_RESET   = 8'h00;
  localparam logic [3:0]  PS_OFF        = 4'h0;

  // ****************************************************
  // Tick source encodings
  // ****************************************************
  localparam logic [1:0]  SRC_LOW_POWER = 2'h0;
  localparam logic [1:0]  SRC_EXT_REF   = 2'h1;
  localparam int          SRC_COUNT     = 3;
  localparam int          IDX_LOW_POWER = 0;
  localparam int          IDX_EXT_REF   = 1;
  localparam int          IDX_INT_REF   = 2;
  localparam int          PRE_W         = 18;

  typedef struct packed {
    logic       flag;
    logic [1:0] src;
    logic       ie;
    logic [3:0] ps;
  } ctrl_t;

  // Divide ratio for a divider select value; bit 0 of the source select picks the long table
  function automatic logic [PRE_W-1:0] divide_ratio(input logic [3:0] ps, input logic long_sel);
    logic [PRE_W-1:0] r;
    r = 18'h00001;
    if (!long_sel) begin
      case (ps)
        4'h1: r = 18'h00008;
        4'h2: r = 18'h00020;
        4'h3: r = 18'h00040;
        4'h4: r = 18'h00080;
        4'h5: r = 18'h00100;
        4'h6: r = 18'h00200;
        4'h7: r = 18'h00400;
        4'h8: r = 18'h00001;
        4'h9: r = 18'h00002;
        4'ha: r = 18'h00004;
        4'hb: r = 18'h0000a;
        4'hc: r = 18'h00010;
        4'hd: r = 18'h00064;
        4'he: r = 18'h001f4;
        4'hf: r = 18'h003e8;
        default: r = 18'h00001;
      endcase
    end else begin
      case (ps)
        4'h1: r = 18'h00400;
        4'h2: r = 18'h00800;
        4'h3: r = 18'h01000;
        4'h4: r = 18'h02000;
        4'h5: r = 18'h04000;
        4'h6: r = 18'h08000;
        4'h7: r = 18'h10000;
        4'h8: r = 18'h003e8;
        4'h9: r = 18'h007d0;
        4'ha: r = 18'h01388;
        4'hb: r = 18'h02710;
        4'hc: r = 18'h04e20;
        4'hd: r = 18'h0c350;
        4'he: r = 18'h186a0;
        4'hf: r = 18'h30d40;
        default: r = 18'h00001;
      endcase
    end
    return r;
  endfunction : divide_ratio

endpackage : tick_pkg

// ==== core/tick_prescaler.sv ====
// Source synchroniser, source select and programmable prescaler of the tick counter
`timescale 1ns/100ps
`default_nettype none
module tick_prescaler
  import tick_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic [SRC_COUNT-1:0] src_raw,
  input  wire logic [1:0]           src_sel,
  input  wire logic [3:0]           ps,
  input  wire logic                 restart,
  input  wire logic                 halt,
  output logic                      tick
);

  logic [SRC_COUNT-1:0] sync1_q;
  logic [SRC_COUNT-1:0] sync2_q;
  logic [SRC_COUNT-1:0] prev_q;
  logic [PRE_W-1:0]     pre_q;
  logic [PRE_W-1:0]     last;
  logic                 src_edge;
  logic                 tick_q;

  // ****************************************************
  // Source clocks come in as levels and are resampled
  // ****************************************************
  // Two stages before any edge logic so a slow source never reaches the counter metastable
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
      prev_q  <= '0;
    end else begin
      sync1_q <= src_raw;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  always_comb begin
    if (src_sel == SRC_LOW_POWER) begin
      src_edge = sync2_q[IDX_LOW_POWER] & ~prev_q[IDX_LOW_POWER];
    end else if (src_sel == SRC_EXT_REF) begin
      src_edge = sync2_q[IDX_EXT_REF] & ~prev_q[IDX_EXT_REF];
    end else begin
      src_edge = sync2_q[IDX_INT_REF] & ~prev_q[IDX_INT_REF];
    end
  end

  // ****************************************************
  // Prescaler
  // ****************************************************
  assign last = divide_ratio(ps, src_sel[0]) - 18'h00001;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pre_q  <= '0;
      tick_q <= 1'b0;
    end else if (restart || ps == PS_OFF) begin
      pre_q  <= '0;
      tick_q <= 1'b0;
    end else if (halt) begin
      // A tick already issued is kept until the halt ends, so no period is lost
      tick_q <= tick_q;
    end else if (src_edge) begin
      tick_q <= (pre_q >= last);
      pre_q  <= (pre_q >= last) ? '0 : pre_q + 18'h00001;
    end else begin
      tick_q <= 1'b0;
    end
  end

  assign tick = tick_q;

endmodule : tick_prescaler
`default_nettype wire

// ==== core/periodic_tick_counter.sv ====
// Periodic tick counter: register slave, 8-bit match counter, sticky match flag and interrupt
//
// The implementer's own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none

// Function
// - Set the match flag, status bit 7, on the tick that finds the count equal to the limit.
// - Writing 0 to the flag does nothing; writing 1 clears it and the request.
// - Source select 00 low-power, 01 external reference, 1x internal reference clock.
// - Writing a changed source select clears prescaler and count.
// - Interrupt request while flag set only when enable bit 4 is one.
// - Divider select bits 3:0 reset to zero; zero stops the prescaler.
// - Short table: 8,32,64,128,256,512,1024 then 1,2,4,10,16,100,500,1000.
// - Long table: 1024 to 65536 by twos, then 1000 up to 200000.
// - Count register reads current count; writes to it are ignored.
// - Count cleared by reset, limit write, or changed source/divider select.
// - On match the count returns to zero and the flag sets.
// - With limit zero, every prescaler tick sets the flag.
// - Any limit write stores it and clears prescaler and count.
// - Reset zeroes limit, flag, interrupt enable and source select.
// - Running counter advances by one per prescaler tick until equal to limit.
// - Flag sets exactly on the limit-to-zero transition.
// - Counting holds during debug halt and resumes from the held value.
module periodic_tick_counter
  import tick_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic [ADDR_W-1:0]    reg_addr,
  input  wire logic [7:0]           reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic [7:0]                reg_rdata,
  input  wire logic                 low_power_oscillator,
  input  wire logic                 external_reference_clock,
  input  wire logic                 internal_reference_clock,
  input  wire logic                 debug_halt,
  output logic                      irq
);

  ctrl_t       ctrl_q;
  ctrl_t       wr_ctrl;
  logic [7:0]  tick_count_q;
  logic [7:0]  match_limit_q;
  logic [7:0]  rdata_q;
  logic        wr_status;
  logic        wr_limit;
  logic        wr_count;
  logic        restart;
  logic        tick;
  logic        match;
  logic        flag_set;

  // ****************************************************
  // Register decode
  // ****************************************************
  assign wr_ctrl = ctrl_t'(reg_wdata);

  always_comb begin
    wr_status = 1'b0;
    wr_limit  = 1'b0;
    wr_count  = 1'b0;
    if (reg_wr && reg_addr == OFF_STATUS) begin
      wr_status = 1'b1;
    end else if (reg_wr && reg_addr == OFF_LIMIT) begin
      wr_limit = 1'b1;
    end else if (reg_wr && reg_addr == OFF_COUNT) begin
      wr_count = 1'b1;
    end
  end

  // A status write restarts only on a changed source or divider select, else it keeps the phase; every limit write restarts
  assign restart = (wr_status && (wr_ctrl.src != ctrl_q.src || wr_ctrl.ps != ctrl_q.ps))
                 || wr_limit;

  // ****************************************************
  // Prescaler
  // ****************************************************
  tick_prescaler u_prescaler (
    .clk     (clk),
    .rst_n   (rst_n),
    .src_raw ({internal_reference_clock, external_reference_clock, low_power_oscillator}),
    .src_sel (ctrl_q.src),
    .ps      (ctrl_q.ps),
    .restart (restart),
    .halt    (debug_halt),
    .tick    (tick)
  );

  // ****************************************************
  // Counter and match
  // ****************************************************
  assign match    = (tick_count_q == match_limit_q);
  // A tick colliding with a restart belongs to the old setting and is dropped
  assign flag_set = tick && match && !restart && !debug_halt;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tick_count_q <= COUNT_RESET;
    end else if (restart) begin
      tick_count_q <= COUNT_RESET;
    end else if (tick && !debug_halt) begin
      if (match) begin
        tick_count_q <= COUNT_RESET;
      end else begin
        tick_count_q <= tick_count_q + 8'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      match_limit_q <= LIMIT_RESET;
    end else if (wr_limit) begin
      match_limit_q <= reg_wdata;
    end
  end

  // ****************************************************
  // Status and control
  // ****************************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_q <= ctrl_t'(CTRL_RESET);
    end else begin
      if (wr_status) begin
        ctrl_q.src <= wr_ctrl.src;
        ctrl_q.ie  <= wr_ctrl.ie;
        ctrl_q.ps  <= wr_ctrl.ps;
      end
      // A match in the clearing cycle wins so no event is lost
      if (flag_set) begin
        ctrl_q.flag <= 1'b1;
      end else if (wr_status && wr_ctrl.flag) begin
        ctrl_q.flag <= 1'b0;
      end
    end
  end

  assign irq = ctrl_q.flag && ctrl_q.ie;

  // ****************************************************
  // Read port
  // ****************************************************
  // Count is a flop in this domain, so a read never sees a half-updated value
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
    end else if (reg_rd && reg_addr == OFF_STATUS) begin
      rdata_q <= ctrl_q;
    end else if (reg_rd && reg_addr == OFF_COUNT) begin
      rdata_q <= tick_count_q;
    end else if (reg_rd && reg_addr == OFF_LIMIT) begin
      rdata_q <= match_limit_q;
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign reg_rdata = rdata_q;

  // ****************************************************
  // Assertions
  // ****************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  AST_FLAG_ON_MATCH: assert property (
    tick && match && !restart && !debug_halt |=> ctrl_q.flag && tick_count_q == 8'h00)
    else $error("match flag not set on match");

  AST_FLAG_W1C: assert property (
    wr_status && wr_ctrl.flag && !flag_set |=> !ctrl_q.flag && !irq)
    else $error("writing one did not clear flag");

  AST_FLAG_W0: assert property (
    ctrl_q.flag && wr_status && !wr_ctrl.flag |=> ctrl_q.flag)
    else $error("writing zero changed flag");

  AST_SRC_RESTART: assert property (
    wr_status && wr_ctrl.src != ctrl_q.src |=> tick_count_q == 8'h00 && !tick)
    else $error("source change did not restart");

  AST_IRQ_GATE: assert property (
    ctrl_q.flag && !ctrl_q.ie |-> !irq ##0 (ctrl_q.ie && ctrl_q.flag) or !irq)
    else $error("interrupt raised while disabled");

  AST_OFF_STILL: assert property (
    ctrl_q.ps == PS_OFF && !restart |=> !tick && $stable(tick_count_q))
    else $error("counter moved with prescaler off");

  AST_COUNT_RO: assert property (
    wr_count && !tick |=> tick_count_q == $past(tick_count_q))
    else $error("write changed count");

  AST_LIMIT_WRITE: assert property (
    wr_limit |=> tick_count_q == 8'h00 && match_limit_q == $past(reg_wdata) && !tick)
    else $error("limit write did not restart");

  AST_WRAP: assert property (
    tick && match && !restart && !debug_halt |=> tick_count_q == 8'h00)
    else $error("count did not wrap on match");

  AST_ZERO_LIMIT: assert property (
    tick && match_limit_q == 8'h00 && !restart && !debug_halt && !wr_status |=> ctrl_q.flag)
    else $error("zero limit tick did not set flag");

  AST_ADVANCE: assert property (
    tick && !match && !restart && !debug_halt |=> tick_count_q == 8'($past(tick_count_q) + 8'h01))
    else $error("count did not advance by one");

  AST_HALT_HOLD: assert property (
    debug_halt && !restart |=> tick_count_q == $past(tick_count_q))
    else $error("count moved during debug halt");

  AST_READ_COUNT: assert property (
    reg_rd && reg_addr == OFF_COUNT |=> reg_rdata == $past(tick_count_q))
    else $error("count read mismatch");

  COV_WRAP_IRQ:   cover property (tick && match && ctrl_q.ie ##1 irq);
  COV_CLEAR_RACE: cover property (flag_set && wr_status && wr_ctrl.flag);
  COV_HALT_TICK:  cover property (debug_halt ##1 !debug_halt ##[1:50] tick);

endmodule : periodic_tick_counter
`default_nettype wire

// ==== sim/tb_top.sv ====
// Self-checking testbench of the periodic tick counter
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin miscompares++; \
  $display("Error %s expected %h seen %h", nm, ex, got); end end
module tb_top;
  import tick_pkg::*;

  logic                 clk;
  logic                 rst_n;
  logic [ADDR_W-1:0]    reg_addr;
  logic [7:0]           reg_wdata;
  logic                 reg_wr;
  logic                 reg_rd;
  logic [7:0]           reg_rdata;
  logic [SRC_COUNT-1:0] src;
  logic                 debug_halt;
  logic                 irq;
  logic                 rd_d;
  logic [7:0]           exp_v;
  logic [7:0]           exp_q[$];
  logic [31:0]          lfsr_q;
  int                   miscompares;
  int                   check_count;
  int                   ratio [16] = '{1, 8, 32, 64, 128, 256, 512, 1024, 1, 2, 4, 10, 16, 100, 500, 1000};

  periodic_tick_counter i_dut (
    .clk                      (clk),
    .rst_n                    (rst_n),
    .reg_addr                 (reg_addr),
    .reg_wdata                (reg_wdata),
    .reg_wr                   (reg_wr),
    .reg_rd                   (reg_rd),
    .reg_rdata                (reg_rdata),
    .low_power_oscillator     (src[IDX_LOW_POWER]),
    .external_reference_clock (src[IDX_EXT_REF]),
    .internal_reference_clock (src[IDX_INT_REF]),
    .debug_halt               (debug_halt),
    .irq                      (irq)
  );

  // ****************************************************
  // Helpers
  // ****************************************************
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  // One strobe cycle, then a released cycle, so back-to-back calls never collide
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk);
    reg_rd   <= 1'b0;
  endtask : rd

  // Source edges two cycles high and two low, then time for the synchronisers to settle
  task automatic edges(input int i, input int n);
    repeat (n) begin
      @(posedge clk);
      src[i] <= 1'b1;
      @(posedge clk);
      @(posedge clk);
      src[i] <= 1'b0;
      @(posedge clk);
    end
    repeat (8) @(posedge clk);
  endtask : edges

  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop

  // ****************************************************
  // Clock, read monitor and watchdog
  // ****************************************************
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Read data stand only in the cycle after the strobe, so sample exactly there
  always @(posedge clk) begin
    rd_d <= reg_rd;
    if (rd_d) begin
      if (exp_q.size() == 0) begin
        miscompares++;
        $display("Error read_data expected none seen %h", reg_rdata);
      end else begin
        exp_v = exp_q.pop_front();
        `CHK("read_data", exp_v, reg_rdata)
      end
    end
  end

  initial begin
    repeat (100000) @(posedge clk);
    miscompares++;
    $display("Error watchdog expected finish seen timeout");
    report_and_stop();
  end

  // ****************************************************
  // Main sequence
  // ****************************************************
  initial begin
    rst_n = 1'b0; reg_addr = '0; reg_wdata = '0; reg_wr = 1'b0; reg_rd = 1'b0;
    src = '0; debug_halt = 1'b0; lfsr_q = 32'h4ec9; miscompares = 0; check_count = 0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rd(OFF_STATUS, 8'h00);
    rd(OFF_COUNT, 8'h00);
    rd(OFF_LIMIT, 8'h00);
    rd(2'h3, 8'h00);
    edges(IDX_LOW_POWER, 3);
    rd(OFF_COUNT, 8'h00);
    repeat (4) begin
      lfsr_q = lfsr(lfsr_q);
      wr(OFF_LIMIT, lfsr_q[7:0]);
      rd(OFF_LIMIT, lfsr_q[7:0]);
    end
    wr(OFF_LIMIT, 8'h02);
    wr(OFF_STATUS, 8'h08);
    for (int k = 1; k <= 3; k++) begin
      edges(IDX_LOW_POWER, 1);
      rd(OFF_COUNT, 8'(k % 3));
    end
    rd(OFF_STATUS, 8'h88);
    wr(OFF_COUNT, 8'h55);
    wr(2'h3, 8'hff);
    rd(OFF_COUNT, 8'h00);
    rd(OFF_LIMIT, 8'h02);
    wr(OFF_STATUS, 8'h18);
    rd(OFF_STATUS, 8'h98);
    #1 `CHK("irq", 1'b1, irq)
    wr(OFF_STATUS, 8'h08);
    #1 `CHK("irq", 1'b0, irq)
    wr(OFF_STATUS, 8'h98);
    rd(OFF_STATUS, 8'h18);
    #1 `CHK("irq", 1'b0, irq)
    wr(OFF_LIMIT, 8'h00);
    repeat (2) begin
      edges(IDX_LOW_POWER, 1);
      rd(OFF_STATUS, 8'h98);
      #1 `CHK("irq", 1'b1, irq)
      wr(OFF_STATUS, 8'h98);
    end
    wr(OFF_STATUS, 8'h88);
    rd(OFF_STATUS, 8'h08);
    // Idle sources get as many edges as the selected one needs, so a wrong pick shows
    wr(OFF_LIMIT, 8'hff);
    for (int s = 0; s < 4; s++) begin
      int r;
      int si;
      r  = (s % 2) ? 1000 : 1;
      si = (s == 0) ? 0 : (s == 1) ? 1 : 2;
      wr(OFF_STATUS, {1'b0, 2'(s), 1'b0, 4'h8});
      edges((si + 1) % 3, r);
      edges((si + 2) % 3, r);
      rd(OFF_COUNT, 8'h00);
      edges(si, r);
      rd(OFF_COUNT, 8'h01);
    end
    for (int p = 1; p < 16; p++) begin
      wr(OFF_STATUS, {4'h0, 4'(p)});
      edges(IDX_LOW_POWER, ratio[p] - 1);
      rd(OFF_COUNT, 8'h00);
      edges(IDX_LOW_POWER, 1);
      rd(OFF_COUNT, 8'h01);
    end
    wr(OFF_STATUS, 8'h21);
    edges(IDX_EXT_REF, 1023);
    rd(OFF_COUNT, 8'h00);
    edges(IDX_EXT_REF, 1);
    rd(OFF_COUNT, 8'h01);
    wr(OFF_STATUS, 8'h08);
    edges(IDX_LOW_POWER, 3);
    wr(OFF_STATUS, 8'h08);
    rd(OFF_COUNT, 8'h03);
    @(posedge clk);
    debug_halt <= 1'b1;
    edges(IDX_LOW_POWER, 2);
    rd(OFF_COUNT, 8'h03);
    @(posedge clk);
    debug_halt <= 1'b0;
    edges(IDX_LOW_POWER, 1);
    rd(OFF_COUNT, 8'h04);
    wr(OFF_LIMIT, 8'h10);
    rd(OFF_COUNT, 8'h00);
    edges(IDX_LOW_POWER, 2);
    wr(OFF_STATUS, 8'h09);
    rd(OFF_COUNT, 8'h00);
    edges(IDX_LOW_POWER, 4);
    rd(OFF_COUNT, 8'h02);
    wr(OFF_STATUS, 8'h49);
    rd(OFF_COUNT, 8'h00);
    // Enable and a running count before a mid-run reset, so the reset values mean something
    wr(OFF_STATUS, 8'h59);
    edges(IDX_INT_REF, 2);
    rd(OFF_COUNT, 8'h01);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd(OFF_STATUS, 8'h00);
    rd(OFF_COUNT, 8'h00);
    rd(OFF_LIMIT, 8'h00);
    repeat (4) @(posedge clk);
    report_and_stop();
  end

endmodule : tb_top
`default_nettype wire
